// [core/dbs_pkg.sv]
/*
  Shared constants and types of the dynamic bus sizer access control.
  Assumes a single bus clock; every sized field here is used by the
  control core or by the port-acknowledge filter, which uses only PW_WAIT.
*/
package dbs_pkg;

  // Host size codes
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LINE = 2'h3;

  // Port acknowledge pair {hi_n, lo_n} doubles as the port width code
  localparam logic [1:0] PW_32   = 2'h0;
  localparam logic [1:0] PW_16   = 2'h1;
  localparam logic [1:0] PW_8    = 2'h2;
  localparam logic [1:0] PW_WAIT = 2'h3;

  // Byte counts of an access
  localparam logic [2:0] BYTES_1 = 3'h1;
  localparam logic [2:0] BYTES_2 = 3'h2;
  localparam logic [2:0] BYTES_4 = 3'h4;

  // Half-clock state numbering
  localparam logic [7:0] HSTATE_RECOG = 8'h02;
  localparam logic [7:0] HSTATE_STEP  = 8'h02;
  localparam logic [7:0] HSTATE_MAX   = 8'hfe;
  localparam logic [7:0] HSTATE_ACK   = 8'h06;

  // Values after reset
  localparam logic        RST_NEG    = 1'b1;
  localparam logic [1:0]  RST_ADDR   = 2'h0;
  localparam logic [15:0] RST_PDATA  = 16'h0000;
  localparam logic [31:0] RST_HDATA  = 32'h00000000;
  localparam logic [7:0]  RST_HSTATE = 8'h00;

  // Width of the bundle of pin inputs that pass the synchroniser
  localparam int SYNC_W = 56;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_START  = 7'h02,
    ST_STROBE = 7'h04,
    ST_TERM   = 7'h08,
    ST_NEXT   = 7'h10,
    ST_ACK    = 7'h20,
    ST_HOLD   = 7'h40
  } dbs_state_t;

endpackage

// [core/dbs_ack_if.sv]
/*
  Carrier between the sizer core and its port-acknowledge filter.
  Assumes both ends run on the same bus clock.
*/
`timescale 1ns/1ps
interface dbs_ack_if;
  logic       sample_en;
  logic [1:0] ack_pair;
  logic       accept;
  logic [1:0] width;

  modport filt (input sample_en, input ack_pair,
                output accept, output width);
  modport ctrl (output sample_en, output ack_pair,
                input accept, input width);
endinterface

// [core/dbs_ack_filter.sv]
/*
  Port acknowledge filter: accepts a port width only after the same
  non-wait code is seen on two successive samples.
  Assumes the acknowledge pair is already synchronised to clk_sys.
*/
`timescale 1ns/1ps
module dbs_ack_filter
  import dbs_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Link to the core
  dbs_ack_if.filt   ack
);

  logic [1:0] prev;
  logic       have_prev;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev      <= PW_WAIT;
      have_prev <= 1'b0;
    end else begin
      prev      <= ack.ack_pair;
      have_prev <= ack.sample_en;
    end
  end

  // A dropped enable clears the history so stale codes are never reused
  assign ack.accept = ack.sample_en && have_prev &&
                      (ack.ack_pair == prev) && (prev != PW_WAIT);
  assign ack.width  = prev;

endmodule

// [core/dbs_core.sv]
/*
  Dynamic bus sizer access control: takes one 32-bit host access and runs
  one to four transfers toward an 8-, 16- or 32-bit peripheral port; a 32-bit port
  access ending past byte 3, or a 16-bit port long or line at offset 3, repeats
  transfers until the select is negated.
  Assumes a host select decoder outside, pins synchronised here, and
  external transceivers for the low 16 data bits of 32-bit ports.
*/
`timescale 1ns/1ps
module dbs_core
  import dbs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Host side
  input  wire logic        host_sel_n,
  input  wire logic        host_rd_wr,
  input  wire logic        size_code_hi,
  input  wire logic        size_code_lo,
  input  wire logic        host_addr_bit1,
  input  wire logic        host_addr_bit0,
  input  wire logic [31:0] host_data_in,
  output logic      [31:0] host_data_out,
  output logic             host_data_hi_oe_n,
  output logic             host_data_lo_oe_n,
  output logic             host_xfer_done_n,
  // Peripheral side
  output logic             periph_addr_bit1,
  output logic             periph_addr_bit0,
  input  wire logic [15:0] periph_data_upper_in,
  output logic      [15:0] periph_data_upper_out,
  output logic             periph_data_upper_oe_n,
  output logic             periph_strobe_n,
  output logic             byte_port_wr_en_n,
  output logic             upper_lane_wr_en_n,
  output logic             lower_lane_wr_en_n,
  input  wire logic        port_ack_hi_n,
  input  wire logic        port_ack_lo_n
);

  ////////////////////////////////////////////////////////////////////////
  // Lane helpers

  // Byte i of a host word sits at bits 31-8i down
  function automatic logic [7:0] byte_of(input logic [31:0] w,
                                         input logic [1:0]  i);
    byte_of = w[8*(3-i) +: 8];
  endfunction

  // Upper lane carries byte off; lower lane carries its odd partner,
  // or the same byte again so 8- and 16-bit ports both see it
  function automatic logic [15:0] wr_lanes(input logic [31:0] w,
                                           input logic [1:0]  off);
    wr_lanes = {byte_of(w, off),
                byte_of(w, off[0] ? off : (off | 2'h1))};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic              sel_s;
  logic              rd_s;
  logic [1:0]        size_s;
  logic [1:0]        addr_s;
  logic [31:0]       data_s;
  logic [15:0]       pdata_s;
  logic [1:0]        pack_s;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_a <= {1'b1, {(SYNC_W-3){1'b0}}, 2'h3};
      sync_b <= {1'b1, {(SYNC_W-3){1'b0}}, 2'h3};
    end else begin
      sync_a <= {host_sel_n, host_rd_wr, size_code_hi, size_code_lo,
                 host_addr_bit1, host_addr_bit0, host_data_in,
                 periph_data_upper_in, port_ack_hi_n, port_ack_lo_n};
      sync_b <= sync_a;
    end
  end

  assign sel_s   = sync_b[55];
  assign rd_s    = sync_b[54];
  assign size_s  = sync_b[53:52];
  assign addr_s  = sync_b[51:50];
  assign data_s  = sync_b[49:18];
  assign pdata_s = sync_b[17:2];
  assign pack_s  = sync_b[1:0];

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge filter

  dbs_ack_if  ack ();
  dbs_state_t state;
  dbs_state_t next_state;

  assign ack.sample_en = (state == ST_START) || (state == ST_STROBE);
  assign ack.ack_pair  = pack_s;

  dbs_ack_filter u_filter (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ack     (ack)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  logic        wr_q;
  logic [2:0]  off;
  logic [2:0]  end_off;
  logic [1:0]  pw_q;
  logic        last_q;
  logic [31:0] wdata_q;
  logic [31:0] rd_buf;
  logic [7:0]  hstate;
  logic        in_xfer;
  logic [2:0]  next_off;
  logic [2:0]  nbytes;

  assign in_xfer = (state == ST_START) || (state == ST_STROBE) ||
                   (state == ST_TERM)  || (state == ST_NEXT);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (!sel_s) next_state = ST_START;
      ST_START:  next_state = ST_STROBE;
      ST_STROBE: if (ack.accept) next_state = ST_TERM;
      ST_TERM:   next_state = last_q ? ST_ACK : ST_NEXT;
      ST_NEXT:   next_state = ST_STROBE;
      ST_ACK:    next_state = ST_HOLD;
      ST_HOLD:   if (sel_s) next_state = ST_IDLE;
    endcase
    // Select dropped mid-access abandons everything gathered so far
    if (in_xfer && sel_s) next_state = ST_IDLE;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) state <= ST_IDLE;
    else     state <= next_state;
  end

  // Access size to byte count; line accesses move a full word
  always_comb begin
    unique case (size_s)
      SIZE_BYTE: nbytes = BYTES_1;
      SIZE_WORD: nbytes = BYTES_2;
      SIZE_LONG: nbytes = BYTES_4;
      SIZE_LINE: nbytes = BYTES_4;
    endcase
  end

  // Offset after a transfer of the accepted width
  always_comb begin
    unique case (ack.width)
      PW_8:    next_off = off + 3'h1;
      PW_16:   next_off = {off[2:1] + 2'h1, 1'b0};
      default: next_off = BYTES_4;
    endcase
  end

  // Host controls and write data are read only at recognition
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_q    <= 1'b0;
      off     <= 3'h0;
      end_off <= 3'h0;
      wdata_q <= RST_HDATA;
    end else if (state == ST_IDLE && !sel_s) begin
      wr_q    <= !rd_s;
      off     <= {1'b0, addr_s};
      end_off <= {1'b0, addr_s} + nbytes;
      wdata_q <= data_s;
    end else if (state == ST_STROBE && ack.accept) begin
      off     <= next_off;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pw_q   <= PW_32;
      last_q <= 1'b0;
    end else if (state == ST_STROBE && ack.accept) begin
      pw_q   <= ack.width;
      last_q <= (next_off >= end_off);
    end
  end

  // Read bytes gathered per transfer; the low two of a 32-bit port
  // travel through the outside transceivers instead
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_buf <= RST_HDATA;
    end else if (state == ST_STROBE && ack.accept && !wr_q) begin
      unique case (ack.width)
        PW_8: rd_buf[8*(3-off[1:0]) +: 8] <= pdata_s[15:8];
        PW_16: begin
          if (off[0]) begin
            rd_buf[8*(3-off[1:0]) +: 8] <= pdata_s[7:0];
          end else begin
            rd_buf[8*(2-off[1:0]) +: 16] <= pdata_s;
          end
        end
        default: rd_buf[31:16] <= pdata_s;
      endcase
    end
  end

  // Even half-states only: each rising edge moves two states
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hstate <= RST_HSTATE;
    end else if (next_state == ST_IDLE) begin
      hstate <= RST_HSTATE;
    end else if (state == ST_IDLE) begin
      hstate <= HSTATE_RECOG;
    end else if (hstate < HSTATE_MAX) begin
      hstate <= hstate + HSTATE_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Peripheral outputs

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      periph_addr_bit1      <= RST_ADDR[1];
      periph_addr_bit0      <= RST_ADDR[0];
      periph_data_upper_out <= RST_PDATA;
    end else if (state == ST_IDLE && !sel_s) begin
      periph_addr_bit1      <= addr_s[1];
      periph_addr_bit0      <= addr_s[0];
      periph_data_upper_out <= wr_lanes(data_s, addr_s);
    end else if (next_state == ST_NEXT) begin
      // Offset already moved on at the accept edge
      periph_addr_bit1      <= off[1];
      periph_addr_bit0      <= off[0];
      periph_data_upper_out <= wr_lanes(wdata_q, off[1:0]);
    end
  end

  // Data floats at the acknowledge, so a slow write must hold off with
  // wait states on its last transfer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      periph_data_upper_oe_n <= RST_NEG;
    end else begin
      periph_data_upper_oe_n <= !(next_state != ST_IDLE &&
                                  next_state != ST_ACK &&
                                  next_state != ST_HOLD &&
                                  (state == ST_IDLE ? !rd_s : wr_q));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      periph_strobe_n    <= RST_NEG;
      byte_port_wr_en_n  <= RST_NEG;
      upper_lane_wr_en_n <= RST_NEG;
      lower_lane_wr_en_n <= RST_NEG;
    end else begin
      periph_strobe_n    <= !(next_state == ST_STROBE);
      byte_port_wr_en_n  <= !(next_state == ST_STROBE && wr_q);
      upper_lane_wr_en_n <= !(next_state == ST_STROBE && wr_q);
      lower_lane_wr_en_n <= !(next_state == ST_STROBE && wr_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host outputs

  logic done_q;
  logic hi_oe_q;
  logic lo_oe_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q        <= RST_NEG;
      hi_oe_q       <= RST_NEG;
      lo_oe_q       <= RST_NEG;
      host_data_out <= RST_HDATA;
    end else begin
      done_q  <= !(next_state == ST_ACK || next_state == ST_HOLD);
      hi_oe_q <= !((next_state == ST_ACK || next_state == ST_HOLD) &&
                   !wr_q);
      // Low half stays off for 32-bit ports to avoid transceiver fights
      lo_oe_q <= !((next_state == ST_ACK || next_state == ST_HOLD) &&
                   !wr_q && pw_q != PW_32);
      if (next_state == ST_ACK) host_data_out <= rd_buf;
    end
  end

  // The raw select releases these at once, with no clock edge between
  assign host_xfer_done_n  = done_q  || host_sel_n;
  assign host_data_hi_oe_n = hi_oe_q || host_sel_n;
  assign host_data_lo_oe_n = lo_oe_q || host_sel_n;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking dbs_chk_clk @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_abort_no_ack: assert property (
    (in_xfer && sel_s) |=> ((state == ST_IDLE) && done_q) [*2])
    else $error("abort did not return to idle quietly");

  a_ack_after_last: assert property (
    (state == ST_TERM && last_q && !sel_s) |=> !done_q ##1 !done_q)
    else $error("acknowledge missing or not held after last transfer");

  a_ack_half_state: assert property (
    $fell(done_q) |-> hstate >= HSTATE_ACK)
    else $error("acknowledge before host state six");

  a_ack_sync_neg: assert property (
    (state == ST_HOLD && sel_s) |=> done_q && state == ST_IDLE)
    else $error("acknowledge not negated on select negation");

  a_ack_comb_neg: assert property (
    host_sel_n |-> host_xfer_done_n && host_data_hi_oe_n)
    else $error("host outputs active with select negated");

  a_idle_quiet: assert property (
    (state == ST_IDLE && $past(state) == ST_IDLE) |->
      done_q && hi_oe_q && lo_oe_q && periph_data_upper_oe_n)
    else $error("idle bus not quiet");

  a_start_strobe: assert property (
    (state == ST_START && !sel_s) |=>
      !periph_strobe_n && (byte_port_wr_en_n == !wr_q) &&
      (upper_lane_wr_en_n == byte_port_wr_en_n))
    else $error("strobe or write enables wrong after start");

  a_term_negates: assert property (
    (state == ST_TERM) |-> periph_strobe_n && byte_port_wr_en_n &&
      upper_lane_wr_en_n && lower_lane_wr_en_n)
    else $error("strobes still asserted after transfer end");

  a_wdata_hold: assert property (
    (state != ST_IDLE && $past(state) != ST_IDLE) |-> $stable(wdata_q))
    else $error("captured write data changed during access");

  a_two_samples: assert property (
    (state == ST_STROBE && ack.accept) |->
      $past(pack_s) == pack_s && $past(ack.sample_en))
    else $error("acknowledge accepted without two equal samples");

  a_read_drive: assert property (
    (state == ST_ACK && !wr_q && !host_sel_n) |-> !host_data_hi_oe_n)
    else $error("read data not driven at acknowledge");

endmodule

// [tb/dbs_periph_model.sv]
/*
  Peripheral port model: an 8-, 16- or 32-bit port with a set number of
  wait cycles per transfer. Assumes the bench picks width and wait before
  each access and leaves them alone while it runs.
*/
`timescale 1ns/1ps
module dbs_periph_model
  import dbs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Set by the bench
  input  wire logic [1:0]  width,
  input  wire logic [3:0]  wait_cyc,
  // Peripheral bus
  input  wire logic        periph_addr_bit1,
  input  wire logic        periph_addr_bit0,
  input  wire logic [15:0] periph_data_upper_out,
  input  wire logic        periph_strobe_n,
  input  wire logic        byte_port_wr_en_n,
  output logic      [15:0] periph_data_upper_in,
  output logic             port_ack_hi_n,
  output logic             port_ack_lo_n,
  // Byte store, byte 0 in [31:24]
  output logic      [31:0] mem_word
);
  logic [7:0] mem [0:3];
  logic [3:0] cnt;
  logic [1:0] ix;

  ////////////////////////////////////////////////////////////////////////
  assign mem_word = {mem[0], mem[1], mem[2], mem[3]};
  // A 32-bit port only shows bytes 0 and 1; the rest pass transceivers
  assign ix = (width == PW_8) ? {periph_addr_bit1, periph_addr_bit0} :
              (width == PW_16) ? {periph_addr_bit1, 1'b0} :
              2'h0;

  always @(posedge clk_sys) begin
    if (rst || periph_strobe_n) begin
      cnt <= 4'h0;
      // Acknowledge lines are pulled up once released
      {port_ack_hi_n, port_ack_lo_n} <= PW_WAIT;
      // Released data must never look like the last value
      periph_data_upper_in <= rst ? 16'h0000 : ~periph_data_upper_in;
      if (rst)
        mem <= '{default: 8'h00};
    end else if (cnt != wait_cyc) begin
      cnt <= cnt + 4'h1;
      periph_data_upper_in <= ~periph_data_upper_in;
    end else begin
      {port_ack_hi_n, port_ack_lo_n} <= width;
      periph_data_upper_in <= (width == PW_8) ? {mem[ix], ~mem[ix]} :
                              {mem[ix], mem[ix + 2'h1]};
      if (!byte_port_wr_en_n) begin
        mem[ix] <= periph_data_upper_out[15:8];
        if (width != PW_8)
          mem[ix + 2'h1] <= periph_data_upper_out[7:0];
      end
    end
  end
endmodule

// [tb/dynamic_bus_sizer_access_control_tb.sv]
/*
  Self-checking bench of the sizer core against the peripheral model.
  Assumes the core's synchroniser delays and the acknowledge OR with
  the select described for its ports.
*/
`timescale 1ns/1ps
module dynamic_bus_sizer_access_control_tb
  import dbs_pkg::*;
;
  typedef struct packed {
    logic        rd;
    logic [31:0] val;
    logic [31:0] mask;
  } dbs_note_t;

  logic        clk_sys, rst, host_sel_n, host_rd_wr;
  logic        size_code_hi, size_code_lo, host_addr_bit1, host_addr_bit0;
  logic [31:0] host_data_in, host_data_out, mem_word;
  logic        host_data_hi_oe_n, host_data_lo_oe_n, host_xfer_done_n;
  logic        periph_addr_bit1, periph_addr_bit0, periph_data_upper_oe_n;
  logic [15:0] periph_data_upper_in, periph_data_upper_out;
  logic        periph_strobe_n, byte_port_wr_en_n;
  logic        upper_lane_wr_en_n, lower_lane_wr_en_n;
  logic        port_ack_hi_n, port_ack_lo_n;
  logic [1:0]  width;
  logic [3:0]  wait_cyc;
  logic [31:0] seed;
  logic [7:0]  shadow [0:3];
  logic        taken;
  dbs_note_t   notes [$];
  int          n_mismatch, checks;

  ////////////////////////////////////////////////////////////////////////
  dbs_core dut (.clk_sys(clk_sys), .rst(rst), .host_sel_n(host_sel_n),
    .host_rd_wr(host_rd_wr), .size_code_hi(size_code_hi),
    .size_code_lo(size_code_lo), .host_addr_bit1(host_addr_bit1),
    .host_addr_bit0(host_addr_bit0), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_hi_oe_n(host_data_hi_oe_n),
    .host_data_lo_oe_n(host_data_lo_oe_n),
    .host_xfer_done_n(host_xfer_done_n), .periph_addr_bit1(periph_addr_bit1),
    .periph_addr_bit0(periph_addr_bit0),
    .periph_data_upper_in(periph_data_upper_in),
    .periph_data_upper_out(periph_data_upper_out),
    .periph_data_upper_oe_n(periph_data_upper_oe_n),
    .periph_strobe_n(periph_strobe_n), .byte_port_wr_en_n(byte_port_wr_en_n),
    .upper_lane_wr_en_n(upper_lane_wr_en_n),
    .lower_lane_wr_en_n(lower_lane_wr_en_n),
    .port_ack_hi_n(port_ack_hi_n), .port_ack_lo_n(port_ack_lo_n));

  dbs_periph_model periph (.clk_sys(clk_sys), .rst(rst), .width(width),
    .wait_cyc(wait_cyc), .periph_addr_bit1(periph_addr_bit1),
    .periph_addr_bit0(periph_addr_bit0),
    .periph_data_upper_out(periph_data_upper_out),
    .periph_strobe_n(periph_strobe_n), .byte_port_wr_en_n(byte_port_wr_en_n),
    .periph_data_upper_in(periph_data_upper_in),
    .port_ack_hi_n(port_ack_hi_n), .port_ack_lo_n(port_ack_lo_n),
    .mem_word(mem_word));

  always #2.5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD t=%0t %s", $time, what);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  // Controls settle three edges ahead of the select, as the sync needs
  task automatic start(input logic rd, input logic [1:0] sz,
                       input logic [1:0] off, input logic [31:0] d);
    host_rd_wr = rd;
    {size_code_hi, size_code_lo} = sz;
    {host_addr_bit1, host_addr_bit0} = off;
    host_data_in = d;
    repeat (3) tick();
    host_sel_n = 1'b0;
  endtask

  task automatic idle();
    repeat (4) begin
      tick();
      host_data_in = rnd();
    end
    check(host_xfer_done_n === 1'b1 && host_data_hi_oe_n === 1'b1 &&
          host_data_lo_oe_n === 1'b1, "host side not idle");
    check(periph_strobe_n === 1'b1 && byte_port_wr_en_n === 1'b1 &&
          periph_data_upper_oe_n === 1'b1, "periph not idle");
  endtask

  // One single access per call, never a burst
  task automatic access(input logic rd, input logic [1:0] sz,
                        input logic [1:0] off, input logic [1:0] pw,
                        input logic [3:0] wt, input int hold);
    logic [31:0] d, m;
    int          n, i;
    d = rnd();
    m = 32'h00000000;
    n = (sz == SIZE_BYTE) ? 1 : (sz == SIZE_WORD) ? 2 : 4;
    for (i = off; i < off + n; i++)
      if (pw != PW_32 || i < 2) begin
        m[31 - 8 * i -: 8] = 8'hff;
        if (!rd)
          shadow[i] = d[31 - 8 * i -: 8];
      end
    notes.push_back('{rd, rd ? {shadow[0], shadow[1], shadow[2],
                     shadow[3]} : d, m});
    width = pw;
    wait_cyc = wt;
    start(rd, sz, off, d);
    i = 0;
    while (host_xfer_done_n !== 1'b0 && i < 200) begin
      tick();
      i++;
      // Past host state four the core must no longer need these
      if (i > 4) begin
        host_data_in = rnd();
        {size_code_hi, size_code_lo} = host_data_in[1:0];
      end
    end
    if (i == 200) begin
      check(1'b0, "no acknowledge");
      final_report();
    end
    repeat (hold) begin
      tick();
      check(host_xfer_done_n === 1'b0, "acknowledge dropped");
      check(host_data_hi_oe_n === !rd, "read drive");
      check(host_data_lo_oe_n === (!rd || pw == PW_32),
            "low half drive");
    end
    host_sel_n = 1'b1;
    #1;
    check(host_xfer_done_n === 1'b1 && host_data_hi_oe_n === 1'b1 &&
          host_data_lo_oe_n === 1'b1, "no direct release");
    idle();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Result watcher: one note per acknowledge, plus lane enable relations
  always @(posedge clk_sys) begin
    if (host_sel_n)
      taken = 1'b0;
    if (!rst && !periph_strobe_n)
      check(byte_port_wr_en_n === host_rd_wr &&
            upper_lane_wr_en_n === host_rd_wr &&
            lower_lane_wr_en_n === host_rd_wr &&
            periph_data_upper_oe_n === host_rd_wr, "write enables");
    if (!rst && !host_sel_n && host_xfer_done_n === 1'b0 && !taken) begin
      taken = 1'b1;
      if (notes.size() == 0)
        check(1'b0, "unexpected acknowledge");
      else
        check(notes[0].rd ? ((host_data_out & notes[0].mask) ===
              (notes[0].val & notes[0].mask)) : ((mem_word & notes[0].mask)
              === (notes[0].val & notes[0].mask)), "data");
      if (notes.size() != 0)
        void'(notes.pop_front());
    end
  end

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    host_sel_n = 1'b1;
    host_rd_wr = 1'b1;
    {size_code_hi, size_code_lo} = 2'h0;
    {host_addr_bit1, host_addr_bit0} = 2'h0;
    host_data_in = 32'h00000000;
    width = PW_8;
    wait_cyc = 4'h0;
    seed = 32'h00000026;
    shadow = '{default: 8'h00};
    taken = 1'b0;
    n_mismatch = 0;
    checks = 0;
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    idle();
    access(1'b0, SIZE_LONG, 2'h0, PW_8, 4'h0, 1);
    access(1'b1, SIZE_LONG, 2'h0, PW_8, 4'h2, 2);
    for (int k = 0; k < 4; k++)
      access(1'b0, SIZE_BYTE, k[1:0], PW_8, k[3:0], k + 1);
    access(1'b0, SIZE_WORD, 2'h2, PW_16, 4'h1, 1);
    access(1'b0, SIZE_LINE, 2'h0, PW_16, 4'h0, 3);
    access(1'b1, SIZE_LINE, 2'h0, PW_16, 4'h1, 2);
    access(1'b1, SIZE_BYTE, 2'h3, PW_16, 4'h3, 1);
    access(1'b0, SIZE_LONG, 2'h0, PW_32, 4'h0, 2);
    access(1'b1, SIZE_LONG, 2'h0, PW_32, 4'h1, 1);
    // Early negation while the slow port still waits
    width = PW_16;
    wait_cyc = 4'hf;
    start(1'b0, SIZE_LONG, 2'h0, rnd());
    repeat (4) tick();
    host_sel_n = 1'b1;
    repeat (20) begin
      tick();
      check(host_xfer_done_n === 1'b1, "abort acknowledged");
    end
    idle();
    access(1'b1, SIZE_LONG, 2'h0, PW_8, 4'h0, 1);
    final_report();
  end
endmodule
